/* File: common/scu_pkg.sv */
// Constants and types for the two-channel serial UART block
// Operation
// - Mode field: 00 clocked, 01 UART, 10 two-wire; only 01 is built, other codes leave the channel idle
// - Interrupt source: transfer end or buffer empty
// - Transmit and receive enables pick direction
// - Error mask bit gates reception error interrupt
// - Transmit parity: none, zero, even, odd
// - Receive parity: none, unchecked, even, odd
// - Bit order: MSB first or LSB first
// - Stop bits: none, one, two
// - Word length: nine, seven or eight bits
// - Divider k gives operation clock over 2(k+1)
// - Example divider 77 gives about 9600 baud
// - Operation clock picks prescaler output zero/one
// - Transfer clock from divider or serial pin
// - Start trigger: software only or receive edge
// - Inversion bit picks falling or rising start
// - Channel 0 transmits, channel 1 receives
// - Transmit line idles at the control register level, high from reset
package scu_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TX_MODE    = 8'h00;
  localparam logic [7:0] ADDR_TX_COMM    = 8'h04;
  localparam logic [7:0] ADDR_TX_DATA    = 8'h08;
  localparam logic [7:0] ADDR_RX_MODE    = 8'h0C;
  localparam logic [7:0] ADDR_RX_COMM    = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA    = 8'h14;
  localparam logic [7:0] ADDR_PRESCALE   = 8'h18;
  localparam logic [7:0] ADDR_CONTROL    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h24;
  // Mode register fields
  localparam int MODE_OPCLK_BIT   = 15;
  localparam int MODE_TRANSFER_CLOCK_BIT    = 14;
  localparam int MODE_TRIG_BIT    = 8;
  localparam int MODE_INV_BIT     = 6;
  localparam int MODE_MD_LSB      = 1;
  localparam int MODE_IRQSRC_BIT  = 0;
  // Communication register fields
  localparam int COMM_TXE_BIT     = 15;
  localparam int COMM_RXE_BIT     = 14;
  localparam int COMM_EOC_BIT     = 10;
  localparam int COMM_PAR_LSB     = 8;
  localparam int COMM_DIR_BIT     = 7;
  localparam int COMM_STOP_LSB    = 4;
  localparam int COMM_LEN_LSB     = 0;
  localparam int DATA_DIV_LSB     = 9;
  // Control register fields
  localparam int CTRL_RX_START    = 0;
  localparam int CTRL_TX_OUT_LVL  = 1;
  // Interrupt status bits
  localparam int IRQ_TX_BIT       = 0;
  localparam int IRQ_RX_BIT       = 1;
  localparam int IRQ_ERR_BIT      = 2;
  localparam int IRQ_WIDTH        = 3;
  // Reset values
  localparam logic [15:0] RST_MODE     = 16'h0022;
  localparam logic [15:0] RST_COMM     = 16'h0097;
  localparam logic [15:0] RST_DATA     = 16'h9A00;
  localparam logic [7:0]  RST_PRESCALE = 8'h00;
  // Encodings
  localparam logic [1:0] MD_UART   = 2'h1;
  localparam logic [1:0] PAR_NONE  = 2'h0;
  localparam logic [1:0] PAR_ZERO  = 2'h1;
  localparam logic [1:0] PAR_EVEN  = 2'h2;
  localparam logic [1:0] STOP_TWO  = 2'h2;
  localparam logic [1:0] LEN_NINE  = 2'h1;
  localparam logic [1:0] LEN_SEVEN = 2'h2;
  // Receive enable to start settling, in system clocks
  localparam int RX_SETTLE_CYCLES = 4;
  // Frame states, Gray along start-data-parity-stop
  typedef enum logic [2:0] {
    SCU_IDLE   = 3'h0,
    SCU_START  = 3'h1,
    SCU_DATA   = 3'h3,
    SCU_PARITY = 3'h2,
    SCU_STOP   = 3'h6
  } scu_state_t;
endpackage : scu_pkg

/* File: rtl/scu_uart.sv */
// Two-channel serial UART: transmit channel 0, receive channel 1, APB
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module scu_uart (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        rxd,
  input  wire logic        sck,
  output logic             txd,
  // Interrupt
  output logic             irq
);
  import scu_pkg::*;

  // Configuration registers
  logic [15:0] tx_channel_mode;          // Channel 0 mode
  logic [15:0] tx_channel_comm_setup;    // Channel 0 communication
  logic [15:0] tx_channel_data_divider;  // Divider and send data
  logic [15:0] rx_channel_mode;          // Channel 1 mode
  logic [15:0] rx_comm_setup;            // Channel 1 communication
  logic [15:0] rx_data_divider;          // Divider and received data
  logic [7:0]  prescaler_select_reg;     // Two 4-bit prescaler fields
  logic        tx_out_level;             // Idle serial output level
  logic [IRQ_WIDTH-1:0] irq_status;      // Sticky events
  logic [IRQ_WIDTH-1:0] irq_mask;        // One enables the event
  logic        tx_go;                    // Write to data launches a frame
  logic        rx_sw_start;              // Software start pulse

  // Pin synchronisers, first stage read only by the second
  logic [1:0] rxd_sync;
  logic [1:0] sck_sync;
  logic       sck_prev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxd_sync <= 2'h3;
      sck_sync <= 2'h0;
      sck_prev <= 1'b0;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd};
      sck_sync <= {sck_sync[0], sck};
      sck_prev <= sck_sync[1];
    end
  end
  logic sck_rise;
  assign sck_rise = sck_sync[1] & ~sck_prev;

  // Free-running prescaler counter
  logic [15:0] pre_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pre_cnt <= 16'h0000;
    else     pre_cnt <= pre_cnt + 16'h0001;
  end

  // One-cycle enable for a divide by 2^sel
  function automatic logic pre_tick(input logic [3:0] sel,
                                    input logic [15:0] cnt);
    logic [15:0] m;
    m = (16'h0001 << sel) - 16'h0001;
    return (cnt & m) == m;
  endfunction : pre_tick

  logic prescaler_out_zero;
  logic prescaler_out_one;
  assign prescaler_out_zero = pre_tick(prescaler_select_reg[3:0], pre_cnt);
  assign prescaler_out_one  = pre_tick(prescaler_select_reg[7:4], pre_cnt);

  // Channel operation clock enable from mode select
  function automatic logic op_clk(input logic [15:0] mode,
                                  input logic z, input logic o);
    return mode[MODE_OPCLK_BIT] ? o : z;
  endfunction : op_clk

  // Data bit count from word length
  function automatic logic [3:0] word_bits(input logic [1:0] len);
    case (len)
      LEN_NINE:  return 4'h9;
      LEN_SEVEN: return 4'h7;
      default:   return 4'h8;
    endcase
  endfunction : word_bits

  // Parity bit for a field setting and data word
  function automatic logic par_bit(input logic [1:0] par,
                                   input logic [8:0] d,
                                   input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - n);
    if (par == PAR_ZERO) return 1'b0;
    return (^(d & m)) ^ (par != PAR_EVEN);
  endfunction : par_bit

  // Half-bit divider: enable every k+1 operation clock ticks
  logic [6:0] tx_div_cnt;
  logic [6:0] rx_div_cnt;
  logic       tx_half;
  logic       rx_half;
  logic       tx_mck;
  logic       rx_mck;
  scu_state_t rx_state;  // Receive frame state
  assign tx_mck = op_clk(tx_channel_mode, prescaler_out_zero,
                         prescaler_out_one);
  assign rx_mck = op_clk(rx_channel_mode, prescaler_out_zero,
                         prescaler_out_one);
  // Each half tick is one half of a transfer clock period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_div_cnt <= 7'h00;
      rx_div_cnt <= 7'h00;
    end else begin
      if (tx_mck)
        tx_div_cnt <= (tx_div_cnt >= tx_channel_data_divider[15:9]) ?
                      7'h00 : tx_div_cnt + 7'h01;
      // Held at zero while idle so samples land mid-bit
      if (rx_state == SCU_IDLE)
        rx_div_cnt <= 7'h00;
      else if (rx_mck)
        rx_div_cnt <= (rx_div_cnt >= rx_data_divider[15:9]) ?
                      7'h00 : rx_div_cnt + 7'h01;
    end
  end
  logic tx_div_half;
  logic rx_div_half;
  assign tx_div_half = tx_mck &
                       (tx_div_cnt >= tx_channel_data_divider[15:9]);
  assign rx_div_half = rx_mck & (rx_div_cnt >= rx_data_divider[15:9]);
  // Pin clock gives a full bit per rising edge: count both as halves
  assign tx_half = tx_channel_mode[MODE_TRANSFER_CLOCK_BIT] ? sck_rise
                                                  : tx_div_half;
  assign rx_half = rx_channel_mode[MODE_TRANSFER_CLOCK_BIT] ? sck_rise
                                                  : rx_div_half;

  // Transmit channel 0
  scu_state_t  tx_state;
  logic [8:0]  tx_shift;
  logic [3:0]  tx_bits;
  logic        tx_phase;
  logic        tx_done;
  logic        tx_buf_empty;
  logic        tx_allowed;
  assign tx_allowed = tx_channel_comm_setup[COMM_TXE_BIT] &&
    (tx_channel_mode[2:1] == MD_UART);
  // Frame sequencer; a pin clock advances a full bit each edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state     <= SCU_IDLE;
      tx_shift     <= 9'h000;
      tx_bits      <= 4'h0;
      tx_phase     <= 1'b0;
      txd          <= 1'b1;
      tx_done      <= 1'b0;
      tx_buf_empty <= 1'b0;
    end else begin
      tx_done      <= 1'b0;
      tx_buf_empty <= 1'b0;
      if (tx_state == SCU_IDLE) begin
        txd      <= tx_out_level;
        tx_phase <= 1'b0;
        if (tx_go && tx_allowed) begin
          tx_shift     <= tx_channel_data_divider[8:0];
          tx_bits      <= 4'h0;
          tx_buf_empty <= 1'b1;
          tx_state     <= SCU_START;
        end
      end else if (tx_half) begin
        tx_phase <= ~tx_phase | tx_channel_mode[MODE_TRANSFER_CLOCK_BIT];
        if (!tx_phase || tx_channel_mode[MODE_TRANSFER_CLOCK_BIT]) begin
          // Bit boundary: put the next frame bit on the line
          case (tx_state)
            SCU_START: begin
              txd      <= 1'b0;
              tx_state <= SCU_DATA;
            end
            SCU_DATA: begin
              // Bit picked by count, word kept whole for parity
              txd <= tx_channel_comm_setup[COMM_DIR_BIT] ?
                tx_shift[tx_bits] :
                tx_shift[word_bits(tx_channel_comm_setup[1:0]) - 4'h1 -
                         tx_bits];
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits + 4'h1 ==
                  word_bits(tx_channel_comm_setup[1:0])) begin
                // No parity: straight on to the stop bits
                tx_bits  <= 4'h0;
                tx_state <= (tx_channel_comm_setup[9:8] == PAR_NONE) ?
                            SCU_STOP : SCU_PARITY;
              end
            end
            SCU_PARITY: begin
              // Sent bits were not shifted away, so parity sees all
              if (tx_channel_comm_setup[9:8] != PAR_NONE) begin
                txd <= par_bit(tx_channel_comm_setup[9:8], tx_shift,
                               word_bits(tx_channel_comm_setup[1:0]));
              end else begin
                txd <= 1'b1;
              end
              tx_bits  <= 4'h0;
              tx_state <= SCU_STOP;
            end
            SCU_STOP: begin
              // Stop bits zero stop bits ends at once
              txd     <= 1'b1;
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits >= {2'h0, tx_channel_comm_setup[5:4]}) begin
                tx_done  <= 1'b1;
                tx_state <= SCU_IDLE;
              end
            end
            default: tx_state <= SCU_IDLE;
          endcase
        end
      end
    end
  end

  // Receive channel 1
  logic [8:0]  rx_shift;
  logic [3:0]  rx_bits;
  logic        rx_phase;
  logic        rx_prev;
  logic        rx_done;
  logic        rx_err;
  logic [2:0]  rx_settle;
  logic        rx_armed;
  logic        rx_line;
  logic        rx_edge;
  // Line after inversion: start bit always reads as zero
  assign rx_line = rxd_sync[1] ^ rx_channel_mode[MODE_INV_BIT];
  assign rx_edge = rx_prev & ~rx_line;
  // Settle counter after receive enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rx_settle <= 3'h0;
    else if (!rx_comm_setup[COMM_RXE_BIT]) rx_settle <= 3'h0;
    else if (rx_settle < 3'(RX_SETTLE_CYCLES))
      rx_settle <= rx_settle + 3'h1;
  end
  assign rx_armed = rx_comm_setup[COMM_RXE_BIT] &&
    (rx_channel_mode[2:1] == MD_UART) &&
    (rx_settle >= 3'(RX_SETTLE_CYCLES));
  // Receive sequencer, sampling at the middle of each bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state        <= SCU_IDLE;
      rx_shift        <= 9'h000;
      rx_bits         <= 4'h0;
      rx_phase        <= 1'b0;
      rx_prev         <= 1'b1;
      rx_done         <= 1'b0;
      rx_err          <= 1'b0;
      rx_data_divider <= RST_DATA;
    end else begin
      rx_prev <= rx_line;
      rx_done <= 1'b0;
      rx_err  <= 1'b0;
      if (psel && penable && pwrite && pready && paddr == ADDR_RX_DATA)
        rx_data_divider[15:9] <= pwdata[15:9];
      if (rx_state == SCU_IDLE) begin
        rx_phase <= 1'b0;
        rx_bits  <= 4'h0;
        // Edge start, or software start when edge is not selected
        if (rx_armed && (rx_channel_mode[MODE_TRIG_BIT] ? rx_edge
                                                        : rx_sw_start))
          rx_state <= SCU_START;
      end else if (rx_half) begin
        // A pin clock edge is a whole bit, so every edge samples
        rx_phase <= ~rx_phase | rx_channel_mode[MODE_TRANSFER_CLOCK_BIT];
        if (!rx_phase || rx_channel_mode[MODE_TRANSFER_CLOCK_BIT]) begin
          // Bit centre
          case (rx_state)
            SCU_START: rx_state <= SCU_DATA;
            SCU_DATA: begin
              // Order bit picks shift direction
              if (rx_comm_setup[COMM_DIR_BIT])
                rx_shift <= {rx_line, rx_shift[8:1]};
              else
                rx_shift <= {rx_shift[7:0], rx_line};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits + 4'h1 == word_bits(rx_comm_setup[1:0]))
                rx_state <= (rx_comm_setup[9:8] == PAR_NONE) ?
                            SCU_STOP : SCU_PARITY;
            end
            SCU_PARITY: begin
              rx_bits <= 4'h0;
              if (rx_comm_setup[9:8] == PAR_NONE) begin
                rx_state <= SCU_STOP;
              end else begin
                // Zero setting takes the bit without checking
                if (rx_comm_setup[9:8] != PAR_ZERO &&
                    rx_line != par_bit(rx_comm_setup[9:8],
                      (rx_comm_setup[COMM_DIR_BIT] ?
                       rx_shift >> (4'h9 - word_bits(rx_comm_setup[1:0]))
                       : rx_shift), word_bits(rx_comm_setup[1:0])))
                  rx_err <= 1'b1;
                rx_state <= SCU_STOP;
              end
            end
            SCU_STOP: begin
              // First stop bit checked for framing
              if (rx_comm_setup[5:4] != 2'h0 && !rx_line)
                rx_err <= 1'b1;
              // LSB-first data sits high: align, drop stale bits
              rx_data_divider[8:0] <= (rx_comm_setup[COMM_DIR_BIT] ?
                rx_shift >> (4'h9 - word_bits(rx_comm_setup[1:0])) :
                rx_shift) &
                (9'h1FF >> (4'h9 - word_bits(rx_comm_setup[1:0])));
              rx_done  <= 1'b1;
              rx_state <= SCU_IDLE;
            end
            default: rx_state <= SCU_IDLE;
          endcase
        end
      end
    end
  end

  // Interrupt events; source bit picks end or buffer empty
  logic [IRQ_WIDTH-1:0] irq_event;
  assign irq_event[IRQ_TX_BIT] = tx_channel_mode[MODE_IRQSRC_BIT] ?
                                 tx_buf_empty : tx_done;
  assign irq_event[IRQ_RX_BIT]  = rx_done;
  assign irq_event[IRQ_ERR_BIT] = rx_err &
                                  rx_comm_setup[COMM_EOC_BIT];

  // APB register writes
  logic wr_en;
  assign wr_en = psel && penable && pwrite && pready;  // Last access cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_channel_mode         <= RST_MODE;
      tx_channel_comm_setup   <= RST_COMM;
      tx_channel_data_divider <= RST_DATA;
      rx_channel_mode         <= RST_MODE;
      rx_comm_setup           <= RST_COMM;
      prescaler_select_reg    <= RST_PRESCALE;
      tx_out_level            <= 1'b1;
      irq_mask                <= '0;
      tx_go                   <= 1'b0;
      rx_sw_start             <= 1'b0;
    end else begin
      tx_go       <= 1'b0;
      rx_sw_start <= 1'b0;
      if (wr_en) begin
        case (paddr)
          ADDR_TX_MODE:  tx_channel_mode       <= pwdata[15:0];
          ADDR_TX_COMM:  tx_channel_comm_setup <= pwdata[15:0];
          ADDR_TX_DATA: begin
            tx_channel_data_divider <= pwdata[15:0];
            tx_go <= 1'b1;
          end
          ADDR_RX_MODE:  rx_channel_mode       <= pwdata[15:0];
          ADDR_RX_COMM:  rx_comm_setup         <= pwdata[15:0];
          ADDR_PRESCALE: prescaler_select_reg  <= pwdata[7:0];
          ADDR_CONTROL: begin
            rx_sw_start  <= pwdata[CTRL_RX_START];
            tx_out_level <= pwdata[CTRL_TX_OUT_LVL];
          end
          ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_WIDTH-1:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky status, write one clears, a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq_status <= '0;
    else irq_status <= (irq_status &
      ~((wr_en && paddr == ADDR_IRQ_STATUS) ? pwdata[IRQ_WIDTH-1:0]
                                             : '0)) | irq_event;
  end

  // Interrupt output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(irq_status & irq_mask);
  end

  // APB read data and answer: one wait state, error on unmapped
  logic mapped;
  assign mapped = (paddr <= ADDR_IRQ_MASK) && (paddr[1:0] == 2'h0);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && !penable) begin
        case (paddr)
          ADDR_TX_MODE:    prdata <= {16'h0000, tx_channel_mode};
          ADDR_TX_COMM:    prdata <= {16'h0000, tx_channel_comm_setup};
          ADDR_TX_DATA:    prdata <= {16'h0000, tx_channel_data_divider};
          ADDR_RX_MODE:    prdata <= {16'h0000, rx_channel_mode};
          ADDR_RX_COMM:    prdata <= {16'h0000, rx_comm_setup};
          ADDR_RX_DATA:    prdata <= {16'h0000, rx_data_divider};
          ADDR_PRESCALE:   prdata <= {24'h000000, prescaler_select_reg};
          ADDR_CONTROL:    prdata <= {29'h0, tx_state != SCU_IDLE,
                                      tx_out_level, rx_state != SCU_IDLE};
          ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status};
          ADDR_IRQ_MASK:   prdata <= {29'h0, irq_mask};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : scu_uart

/* File: tb/scu_uart_monitor.sv */
// Port-level assertions for the serial UART block
`timescale 1ns/100ps
module scu_uart_monitor
  import scu_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial pins and interrupt
  input wire logic        rxd,
  input wire logic        sck,
  input wire logic        txd,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Address with no register behind it
  wire logic bad_addr = (paddr > ADDR_IRQ_MASK) || (paddr[1:0] != 2'h0);
  AST_IDLE_AFTER_RESET: assert property ($fell(rst) |-> txd && !irq)
    else $error("txd not idle high after reset");
  AST_BIT_MIN_WIDTH: assert property ($changed(txd) |=> $stable(txd))
    else $error("serial bit shorter than two clocks");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ONE_WAIT: assert property ((psel && !penable) ##1
    (psel && penable && !pready) |=> pready)
    else $error("pready not in second access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_DECODE: assert property (pready |-> (pslverr == bad_addr))
    else $error("pslverr does not match address decode");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  AST_PRDATA_HOLD: assert property (pready ##1 !psel |-> $stable(prdata))
    else $error("read data not held after transfer");
  // Main scenarios seen
  COV_ERR: cover property (pready && pslverr);
  COV_TX_LAUNCH: cover property (pready && pwrite && paddr == ADDR_TX_DATA);
  COV_IRQ: cover property ($rose(irq));
endmodule : scu_uart_monitor

bind scu_uart scu_uart_monitor i_mon (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .sck(sck), .txd(txd), .irq(irq));

/* File: tb/scu_remote_uart.sv */
// Remote serial device model on the transmit and receive lines
`timescale 1ns/100ps
module scu_remote_uart #(
  parameter int BIT_CYC = 8  // Clocks per bit on both lines
) (
  // Clock
  input wire logic        mclk,
  // Serial lines
  input wire logic        txd,
  output logic            rxd,
  // Frame control from the bench
  input wire logic [3:0]  nbits,
  input wire logic        send,
  input wire logic [11:0] rx_bits,
  output logic [11:0]     got,
  output int              got_cnt
);
  // Receive line idles high, nothing captured yet
  initial begin
    rxd = 1'b1;
    got = 12'h000;
    got_cnt = 0;
  end
  // Capture a frame mid-bit after the start edge
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      got[i] = txd;
    end
    got_cnt++;
  end
  // Drive start bit then bits in wire order, back to idle
  always @(posedge send) begin
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= rx_bits[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    rxd <= 1'b1;
  end
endmodule : scu_remote_uart

/* File: tb/testbench.sv */
// Self-checking bench for the serial UART block
`timescale 1ns/100ps
module testbench;
  import scu_pkg::*;
  localparam int K = 3;            // Divider field, short bits
  localparam int BIT_CYC = 2 * (K + 1);
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, send = 1'b0, sck = 1'b0, pready, pslverr, txd, rxd;
  logic irq, err, ia;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h585C69A7;
  logic [3:0]  nbits = 4'h0;
  logic [11:0] fb = 12'h000, got;
  logic [8:0]  d9;
  int got_cnt, num_errors = 0, cmp_count = 0, n, c0;
  // Communication setups: parity, order, stop and length variety
  logic [15:0] cfg [5] = '{16'h8097, 16'h8217, 16'h83A6, 16'h8195, 16'h8087};

  always #2 mclk = ~mclk;

  scu_uart i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .sck(sck), .txd(txd),
    .irq(irq));
  scu_remote_uart #(.BIT_CYC(BIT_CYC)) i_far (.mclk(mclk), .txd(txd),
    .rxd(rxd), .nbits(nbits), .send(send), .rx_bits(fb), .got(got),
    .got_cnt(got_cnt));

  // Repeatable random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Wire image of a frame after its start bit
  function automatic logic [11:0] frame(input logic [8:0] d,
    input logic [15:0] c, output int nb);
    int len;
    logic p;
    frame = 12'h000;
    p = 1'b0;
    len = (c[1:0] == LEN_NINE) ? 9 : (c[1:0] == LEN_SEVEN) ? 7 : 8;
    for (int i = 0; i < len; i++) begin
      frame[i] = c[COMM_DIR_BIT] ? d[i] : d[len-1-i];
      p ^= d[i];
    end
    nb = len;
    if (c[9:8] != PAR_NONE) begin
      frame[nb] = (c[9:8] == PAR_ZERO) ? 1'b0 : (c[9:8] == PAR_EVEN) ? p : ~p;
      nb++;
    end
    for (int i = 0; i < c[5:4]; i++) begin
      frame[nb] = 1'b1;
      nb++;
    end
  endfunction : frame

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic timeout(input string what);
    num_errors++;
    $display("ERROR %s expected completion, seen timeout", what);
    give_verdict();
  endtask : timeout

  task automatic chk(input string what, input logic [31:0] exp, act);
    cmp_count++;
    if (act !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
      if (i == 20) timeout("apb");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    apb(0, ADDR_TX_MODE, 0); chk("tx mode", RST_MODE, rd);
    apb(0, ADDR_TX_COMM, 0); chk("tx comm", RST_COMM, rd);
    apb(0, ADDR_TX_DATA, 0); chk("tx data", RST_DATA, rd);
    apb(0, 8'h30, 0); chk("unmapped", 1, err);
    // Each mode code and interrupt source reads back
    for (int m = 0; m < 3; m++) begin
      apb(1, ADDR_TX_MODE, 32'h20 | (m << MODE_MD_LSB) | m[0]);
      apb(0, ADDR_TX_MODE, 0);
      chk("mode", 32'h20 | (m << MODE_MD_LSB) | m[0], rd);
    end
    apb(1, ADDR_TX_MODE, RST_MODE);
    // Receive-only direction must not send
    apb(1, ADDR_TX_COMM, 16'h4097);
    c0 = got_cnt;
    apb(1, ADDR_TX_DATA, K << DATA_DIV_LSB);
    repeat (20 * BIT_CYC) @(posedge mclk);
    chk("no frame", c0, got_cnt);
    // Random frames under each setup
    for (int j = 0; j < 10; j++) begin
      d9 = 9'(rnd());
      fb = frame(d9, cfg[j/2], n);
      nbits <= 4'(n);
      apb(1, ADDR_TX_COMM, cfg[j/2]);
      c0 = got_cnt;
      apb(1, ADDR_TX_DATA, (K << DATA_DIV_LSB) | d9);
      for (int i = 0; got_cnt <= c0; i++) begin
        @(posedge mclk);
        if (i == 20 * BIT_CYC) timeout("frame");
      end
      repeat (BIT_CYC) @(posedge mclk);
      chk("tx frame", fb, got & 12'((1 << n) - 1));
    end
    // Pin transfer clock, one whole bit per rising edge
    fb = frame(9'h0A5, cfg[4], n);
    nbits <= 4'(n);
    apb(1, ADDR_TX_MODE, RST_MODE | (1 << MODE_TRANSFER_CLOCK_BIT));
    c0 = got_cnt;
    apb(1, ADDR_TX_DATA, 9'h0A5);
    for (int i = 0; got_cnt <= c0; i++) begin
      @(posedge mclk);
      sck <= i[2];
      if (i == 20 * BIT_CYC) timeout("pin clock");
    end
    chk("pin clock", fb, got & 12'((1 << n) - 1));
    apb(1, ADDR_TX_MODE, RST_MODE);
    apb(0, ADDR_IRQ_STATUS, 0); chk("tx end", 1, rd[IRQ_TX_BIT]);
    apb(1, ADDR_IRQ_STATUS, 7);
    apb(0, ADDR_IRQ_STATUS, 0); chk("status clear", 0, rd[2:0]);
    // Edge-started reception, good then bad even parity
    apb(1, ADDR_RX_MODE, 16'h0122);
    apb(1, ADDR_RX_DATA, K << DATA_DIV_LSB);
    for (int j = 0; j < 2; j++) begin
      apb(1, ADDR_RX_COMM, 16'h4697);
      repeat (RX_SETTLE_CYCLES) @(posedge mclk); // settle
      d9 = {1'b0, 8'(rnd())};
      fb = frame(d9, 16'h4697, n);
      fb[8] ^= j[0];
      nbits <= 4'(n);
      send <= 1'b1;
      @(posedge mclk);
      send <= 1'b0;
      repeat ((n + 3) * BIT_CYC) @(posedge mclk);
      apb(0, ADDR_IRQ_STATUS, 0); chk("rx err", j[0], rd[IRQ_ERR_BIT]);
      if (j == 0) begin
        chk("rx done", 1, rd[IRQ_RX_BIT]);
        apb(0, ADDR_RX_DATA, 0); chk("rx data", d9, rd[8:0]);
        apb(1, ADDR_IRQ_MASK, 0);
        repeat (2) @(posedge mclk);
        ia = irq;
        apb(1, ADDR_IRQ_MASK, 7);
        repeat (2) @(posedge mclk);
        chk("irq masked", 0, ia);
        chk("irq mask", 1, irq);
      end
      apb(1, ADDR_IRQ_STATUS, 7);
      repeat (2) @(posedge mclk);
      chk("irq clear", 0, irq);
    end
    give_verdict();
  end
endmodule : testbench
